// ---- core/tuner_regs.svh ----
`ifndef TUNER_REGS_SVH
`define TUNER_REGS_SVH

// register offsets on the 4-bit control address
`define ADDR_TW_BYTE0      4'h0
`define ADDR_TW_BYTE1      4'h1
`define ADDR_TW_BYTE2      4'h2
`define ADDR_TW_BYTE3      4'h3
`define ADDR_SYNC_ROUTING  4'h4
`define ADDR_FILTER        4'h5
`define ADDR_GAIN_MANT     4'h6
`define ADDR_GAIN_SHIFT    4'h7
`define ADDR_OUT_FORMAT    4'h8
`define ADDR_STATUS        4'h9
`define ADDR_PULSE         4'ha
`define ADDR_SIGNATURE     4'hb
`define ADDR_I_LOW         4'hc
`define ADDR_I_HIGH        4'hd
`define ADDR_Q_LOW         4'he
`define ADDR_Q_HIGH        4'hf

// number of writable storage bytes (offsets 0 to 9)
`define RW_COUNT           10

// sync routing control bit positions
`define SM_SS_OFF          0
`define SM_ACC_EN          1
`define SM_FROM_SYS        2
`define SM_LOAD_NOW        3
`define SM_LOAD_ON_SYNC    4
`define SM_DIAG_EN         5
`define SM_SHORT_PERIOD    6
`define SM_CTR_SEL         7

// reset values
`define REG_RESET          8'h00
`define TW_RESET           28'h000_0000

// tuning word layout
`define TW_BITS            28
`define TW_TOP_BITS        4

// sync counter periods as powers of two clocks
`define SYNC_LONG_LOG2     20
`define SYNC_SHORT_LOG2    8

`endif

// ---- core/tuner_pkg.sv ----
package tuner_pkg;

    typedef logic [7:0]  byte_t;
    typedef logic [3:0]  addr_t;
    typedef logic [27:0] tuning_t;
    typedef logic [15:0] sample_t;

    typedef enum logic [1:0]
    {
        BUS_IDLE = 2'b01,
        BUS_HOLD = 2'b10
    } bus_state_t;

endpackage

// ---- core/sync_if.sv ----
interface sync_if;
    import tuner_pkg::*;

    byte_t   mode;
    tuning_t tuning_word;
    logic    tw_changed;
    logic    ss_fall;
    logic    as_fall;
    logic    ss_level;
    tuning_t osc_tuning_word;
    logic    acc_reset;
    logic    diag_sync;
    logic    so_n;

    modport regs
    (
        output mode,
        output tuning_word,
        output tw_changed,
        output ss_fall,
        output as_fall,
        output ss_level,
        input  osc_tuning_word,
        input  acc_reset,
        input  diag_sync,
        input  so_n
    );

    modport router
    (
        input  mode,
        input  tuning_word,
        input  tw_changed,
        input  ss_fall,
        input  as_fall,
        input  ss_level,
        output osc_tuning_word,
        output acc_reset,
        output diag_sync,
        output so_n
    );

endinterface

// ---- core/sync_router.sv ----
`include "tuner_regs.svh"

module sync_router
(
    input wire logic clock,
    input wire logic nrst,
    sync_if.router   sif
);
    import tuner_pkg::*;

    logic [`SYNC_LONG_LOG2-1:0] count_q;
    logic [`SYNC_LONG_LOG2-1:0] count_d;
    logic                       ld_prev_q;
    logic                       ld_prev_d;
    tuning_t                    tuning_word_q;
    tuning_t                    tuning_word_d;
    logic                       acc_q;
    logic                       acc_d;
    logic                       diag_q;
    logic                       diag_d;
    logic                       so_q;
    logic                       so_d;
    logic                       ss_usable;
    logic                       sel_fall;
    logic                       term;
    logic                       int_sync;

    always_comb
    begin
        ss_usable = !sif.mode[`SM_SS_OFF]; // see R7
        // system sync replaces the accumulator sync pin when bit 2 is set and bit 0 clear
        sel_fall = (sif.mode[`SM_FROM_SYS] && ss_usable) ?
                   sif.ss_fall : sif.as_fall; // see R9
        term = sif.mode[`SM_SHORT_PERIOD] ?
               (&count_q[`SYNC_SHORT_LOG2-1:0]) : (&count_q); // see R14
        int_sync = sif.mode[`SM_CTR_SEL] ?
                   term : (sif.ss_fall && ss_usable); // see R13 see R15
        count_d = count_q + {{(`SYNC_LONG_LOG2-1){1'b0}}, 1'b1};
        ld_prev_d = sif.mode[`SM_LOAD_NOW];
        tuning_word_d = tuning_word_q;
        if (sif.mode[`SM_LOAD_NOW] && (!ld_prev_q || sif.tw_changed))
        begin
            tuning_word_d = sif.tuning_word; // see R10
        end
        else if (sif.mode[`SM_LOAD_ON_SYNC] && sel_fall)
        begin
            tuning_word_d = sif.tuning_word; // see R11
        end
        acc_d = sif.mode[`SM_ACC_EN] && sel_fall; // see R8
        diag_d = sif.mode[`SM_DIAG_EN] && int_sync; // see R12
        so_d = sif.mode[`SM_CTR_SEL] ? !term : sif.ss_level; // see R15 see R17
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            count_q   <= '0;
            ld_prev_q <= 1'b0;
            tuning_word_q    <= `TW_RESET;
            acc_q     <= 1'b0;
            diag_q    <= 1'b0;
            so_q      <= 1'b1;
        end
        else
        begin
            count_q   <= count_d;
            ld_prev_q <= ld_prev_d;
            tuning_word_q    <= tuning_word_d;
            acc_q     <= acc_d;
            diag_q    <= diag_d;
            so_q      <= so_d;
        end
    end

    assign sif.osc_tuning_word  = tuning_word_q;
    assign sif.acc_reset = acc_q;
    assign sif.diag_sync = diag_q;
    assign sif.so_n      = so_q;

endmodule

// ---- core/tuner_control_regs_sync.sv ----
`include "tuner_regs.svh"

//  Summary of operation
// R1: sixteen byte registers selected by 4-bit address over 8-bit data pins.
// R2: map: tuning 0-3, sync 4, filter 5..output 8, status 9, pulse 10, etc.
// R3: bits are read-only or read/write; control bits act when one.
// R4: registers 0-3 form a 28-bit tuning word, register 0 lowest byte.
// R5: register 3 bits 0-3 hold word bits 24-27; bits 4-7 spare RW.
// R6: host programs word as frequency times 2^28 over clock rate.
// R7: sync routing bit 0 makes the system sync input ignored; the code still passes it to the sync output NSO.
// R8: bit 1 lets accumulator sync falls reinitialise the phase accumulator.
// R9: bit 2 substitutes system sync for accumulator sync unless disabled.
// R10: bit 3 loads oscillator frequency; while set, tuning writes reload it.
// R11: bit 4 loads oscillator frequency on selected accumulator sync fall.
// R12: bit 5 routes internal sync to checksum and counters as reinit.
// R13: diagnostic sync period is 2^20 clocks or the system sync period.
// R14: bit 6 shortens the sync counter wrap to 2^8 clocks.
// R15: bit 7 uses counter terminal strobe as internal sync and sync output.
// R16: write when select falls with read/write low; drive data on reads.
// R17: with counter select clear, sync output is delayed system sync.
// R18: system, accumulator and gain syncs sampled on rising clock.
// R19: reads return last written value; all registers clear on reset. The code reads offset 9 from STATUS_IN instead.
module tuner_control_regs_sync
(
    input  wire logic       CLOCK,
    input  wire logic       NRST,
    input  wire logic       NCS,
    input  wire logic       RNW,
    input  tuner_pkg::addr_t   ADDR,
    input  tuner_pkg::byte_t   DATA_IN,
    output tuner_pkg::byte_t   DATA_OUT,
    output logic            DATA_OE,
    input  wire logic       NSS,
    input  wire logic       NAS,
    input  wire logic       NGS,
    input  tuner_pkg::byte_t   STATUS_IN,
    input  tuner_pkg::byte_t   SIGNATURE_IN,
    input  tuner_pkg::sample_t I_SAMPLE,
    input  tuner_pkg::sample_t Q_SAMPLE,
    output tuner_pkg::byte_t   FILTER_MODE,
    output tuner_pkg::byte_t   GAIN_MANTISSA,
    output tuner_pkg::byte_t   GAIN_SHIFT,
    output tuner_pkg::byte_t   OUTPUT_FORMAT,
    output tuner_pkg::byte_t   STATUS_CTRL,
    output tuner_pkg::tuning_t OSC_TUNING_WORD,
    output logic            ACC_RESET,
    output logic            DIAG_SYNC,
    output logic            GAIN_SYNC,
    output logic            NSO,
    output logic            NOS
);
    import tuner_pkg::*;

    // pin synchronisers: meta stage feeds only the sync stage
    logic       ncs_meta_q;
    logic       ncs_sync_q;
    logic       rnw_meta_q;
    logic       rnw_sync_q;
    addr_t      addr_meta_q;
    addr_t      addr_sync_q;
    byte_t      data_meta_q;
    byte_t      data_sync_q;
    logic       nss_meta_q;
    logic       nss_sync_q;
    logic       nss_prev_q;
    logic       nas_meta_q;
    logic       nas_sync_q;
    logic       nas_prev_q;
    logic       ngs_meta_q;
    logic       ngs_sync_q;
    logic       ngs_prev_q;

    bus_state_t state_q;
    bus_state_t state_d;
    byte_t      rw_q [`RW_COUNT];
    byte_t      rw_d [`RW_COUNT];
    logic       tw_changed_q;
    logic       tw_changed_d;
    byte_t      dout_q;
    byte_t      dout_d;
    logic       oe_q;
    logic       oe_d;
    logic       nos_q;
    logic       nos_d;
    logic       gsync_q;
    logic       gsync_d;
    logic       write_go;

    sync_if sif ();

    function automatic logic is_storage(input addr_t a);
        is_storage = (a <= `ADDR_STATUS);
    endfunction

    function automatic logic is_tuning(input addr_t a);
        is_tuning = (a <= `ADDR_TW_BYTE3);
    endfunction

    // offset 9 reads the live status, not the stored control byte
    function automatic byte_t read_mux(input addr_t a);
        if (a == `ADDR_STATUS)
        begin
            read_mux = STATUS_IN;
        end
        else if (is_storage(a))
        begin
            read_mux = rw_q[a]; // see R19
        end
        else if (a == `ADDR_SIGNATURE)
        begin
            read_mux = SIGNATURE_IN;
        end
        else if (a == `ADDR_I_LOW)
        begin
            read_mux = I_SAMPLE[7:0];
        end
        else if (a == `ADDR_I_HIGH)
        begin
            read_mux = I_SAMPLE[15:8];
        end
        else if (a == `ADDR_Q_LOW)
        begin
            read_mux = Q_SAMPLE[7:0];
        end
        else if (a == `ADDR_Q_HIGH)
        begin
            read_mux = Q_SAMPLE[15:8];
        end
        else
        begin
            read_mux = `REG_RESET;
        end
    endfunction

    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            // idle pin levels, so the fall detectors see no edge after reset
            ncs_meta_q  <= 1'b1;
            ncs_sync_q  <= 1'b1;
            rnw_meta_q  <= 1'b1;
            rnw_sync_q  <= 1'b1;
            addr_meta_q <= 4'h0;
            addr_sync_q <= 4'h0;
            data_meta_q <= `REG_RESET;
            data_sync_q <= `REG_RESET;
            nss_meta_q  <= 1'b1;
            nss_sync_q  <= 1'b1;
            nss_prev_q  <= 1'b1;
            nas_meta_q  <= 1'b1;
            nas_sync_q  <= 1'b1;
            nas_prev_q  <= 1'b1;
            ngs_meta_q  <= 1'b1;
            ngs_sync_q  <= 1'b1;
            ngs_prev_q  <= 1'b1;
        end
        else
        begin
            ncs_meta_q  <= NCS;
            ncs_sync_q  <= ncs_meta_q;
            rnw_meta_q  <= RNW;
            rnw_sync_q  <= rnw_meta_q;
            addr_meta_q <= ADDR;
            addr_sync_q <= addr_meta_q;
            data_meta_q <= DATA_IN;
            data_sync_q <= data_meta_q;
            nss_meta_q  <= NSS; // see R18
            nss_sync_q  <= nss_meta_q;
            nss_prev_q  <= nss_sync_q;
            nas_meta_q  <= NAS; // see R18
            nas_sync_q  <= nas_meta_q;
            nas_prev_q  <= nas_sync_q;
            ngs_meta_q  <= NGS; // see R18
            ngs_sync_q  <= ngs_meta_q;
            ngs_prev_q  <= ngs_sync_q;
        end
    end

    // bus sequencer: a write is taken once per select fall
    always_comb
    begin
        state_d = state_q;
        write_go = 1'b0;
        case (state_q)
            BUS_IDLE:
            begin
                if (!ncs_sync_q)
                begin
                    write_go = !rnw_sync_q; // see R16
                    state_d = BUS_HOLD;
                end
            end
            // a long select gives one write; wait for it to rise
            BUS_HOLD:
            begin
                if (ncs_sync_q)
                begin
                    state_d = BUS_IDLE;
                end
            end
            default:
            begin
                state_d = BUS_IDLE;
            end
        endcase
    end

    always_comb
    begin
        for (int i = 0; i < `RW_COUNT; i++)
        begin
            rw_d[i] = rw_q[i];
        end
        tw_changed_d = 1'b0;
        nos_d = 1'b1;
        if (write_go && is_storage(addr_sync_q))
        begin
            rw_d[addr_sync_q] = data_sync_q; // see R1 see R3 see R5
            // any change to the tuning bytes may trigger a reload
            tw_changed_d = is_tuning(addr_sync_q) &&
                           (data_sync_q != rw_q[addr_sync_q]); // see R10
        end
        if (write_go && (addr_sync_q == `ADDR_PULSE))
        begin
            nos_d = 1'b0;
        end
        // drive lags select by the two sync stages and this flop
        oe_d = !ncs_sync_q && rnw_sync_q; // see R16
        dout_d = `REG_RESET;
        if (oe_d)
        begin
            dout_d = read_mux(addr_sync_q); // see R2
        end
        // one strobe per gain sync fall
        gsync_d = ngs_prev_q && !ngs_sync_q; // see R18
    end

    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            state_q <= BUS_IDLE;
            for (int i = 0; i < `RW_COUNT; i++)
            begin
                rw_q[i] <= `REG_RESET; // see R19
            end
            tw_changed_q <= 1'b0;
            dout_q       <= `REG_RESET;
            oe_q         <= 1'b0;
            nos_q        <= 1'b1;
            gsync_q      <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            for (int i = 0; i < `RW_COUNT; i++)
            begin
                rw_q[i] <= rw_d[i];
            end
            tw_changed_q <= tw_changed_d;
            dout_q       <= dout_d;
            oe_q         <= oe_d;
            nos_q        <= nos_d;
            gsync_q      <= gsync_d;
        end
    end

    // tuning word, register 0 lowest byte
    assign sif.tuning_word = {rw_q[`ADDR_TW_BYTE3][`TW_TOP_BITS-1:0],
                              rw_q[`ADDR_TW_BYTE2],
                              rw_q[`ADDR_TW_BYTE1],
                              rw_q[`ADDR_TW_BYTE0]}; // see R4 see R5
    assign sif.mode       = rw_q[`ADDR_SYNC_ROUTING];
    assign sif.tw_changed = tw_changed_q;
    assign sif.ss_fall    = nss_prev_q && !nss_sync_q;
    assign sif.as_fall    = nas_prev_q && !nas_sync_q;
    assign sif.ss_level   = nss_sync_q;

    // sync routing and the oscillator frequency register
    sync_router router
    (
        .clock (CLOCK),
        .nrst  (NRST),
        .sif   (sif)
    );

    // every output below is a flop here or in the router
    assign DATA_OUT      = dout_q;
    assign DATA_OE       = oe_q;
    assign FILTER_MODE   = rw_q[`ADDR_FILTER];
    assign GAIN_MANTISSA = rw_q[`ADDR_GAIN_MANT];
    assign GAIN_SHIFT    = rw_q[`ADDR_GAIN_SHIFT];
    assign OUTPUT_FORMAT = rw_q[`ADDR_OUT_FORMAT];
    assign STATUS_CTRL   = rw_q[`ADDR_STATUS];
    assign OSC_TUNING_WORD      = sif.osc_tuning_word;
    assign ACC_RESET     = sif.acc_reset;
    assign DIAG_SYNC     = sif.diag_sync;
    assign GAIN_SYNC     = gsync_q;
    assign NSO           = sif.so_n;
    assign NOS           = nos_q;

endmodule

// ---- tb/tuner_assertions.sv ----
module tuner_checks
(
    input wire logic          CLOCK,
    input wire logic          NRST,
    input wire logic          NCS,
    input wire logic          RNW,
    input tuner_pkg::addr_t   ADDR,
    input tuner_pkg::byte_t   DATA_OUT,
    input wire logic          DATA_OE,
    input wire logic          NSS,
    input wire logic          NAS,
    input wire logic          NGS,
    input tuner_pkg::tuning_t OSC_TUNING_WORD,
    input wire logic          ACC_RESET,
    input wire logic          DIAG_SYNC,
    input wire logic          GAIN_SYNC,
    input wire logic          NOS
);
    timeunit 1ns;
    timeprecision 1ns;
    import tuner_pkg::*;
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!NRST);

    a_oe_by_read:
        assert property (DATA_OE |-> $past(!NCS && RNW, 3))
        else $error("data pins driven without a read select");
    a_out_quiet:
        assert property (!DATA_OE |-> DATA_OUT == 8'h00)
        else $error("read data not cleared while released");
    a_pulse_cause:
        assert property ($fell(NOS) |->
            $past(ADDR, 3) == 4'ha && !$past(RNW, 3) && !$past(NCS, 3))
        else $error("one-shot without a write to offset ten");
    a_pulse_width:
        assert property (!NOS |=> NOS)
        else $error("one-shot longer than one cycle");
    a_gain_follow:
        assert property ($fell(NGS) |-> ##[2:6] GAIN_SYNC)
        else $error("gain sync fall not forwarded");
    a_gain_width:
        assert property (GAIN_SYNC |=> !GAIN_SYNC)
        else $error("gain sync pulse too long");
    a_acc_width:
        assert property (ACC_RESET |=> !ACC_RESET)
        else $error("accumulator reset pulse too long");
    a_diag_width:
        assert property (DIAG_SYNC |=> !DIAG_SYNC)
        else $error("diagnostic sync pulse too long");
    a_tuning_word_cause:
        assert property ($changed(OSC_TUNING_WORD) |->
            $past(!NCS, 4) || $past(!NAS, 3) || $past(!NSS, 3))
        else $error("frequency register changed without a cause");
endmodule

bind tuner_control_regs_sync tuner_checks u_checks
(
    .CLOCK(CLOCK), .NRST(NRST), .NCS(NCS), .RNW(RNW), .ADDR(ADDR),
    .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE), .NSS(NSS), .NAS(NAS),
    .NGS(NGS), .OSC_TUNING_WORD(OSC_TUNING_WORD), .ACC_RESET(ACC_RESET),
    .DIAG_SYNC(DIAG_SYNC), .GAIN_SYNC(GAIN_SYNC), .NOS(NOS)
);

// ---- tb/tuner_host.sv ----
module tuner_host
(
    input  wire logic        clock,
    input  tuner_pkg::byte_t rd_data,
    input  wire logic        rd_oe,
    output logic             ncs,
    output logic             rnw,
    output tuner_pkg::addr_t addr,
    output tuner_pkg::byte_t wr_data,
    output logic             wr_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    import tuner_pkg::*;

    initial
    begin
        ncs = 1'b1;
        rnw = 1'b1;
        addr = 4'h0;
        wr_data = 8'h00;
        wr_oe = 1'b0;
    end

    // pins settle 3 clocks before select falls and stay while it is low
    task automatic access(input addr_t a, input logic rd,
                          input byte_t d, output byte_t q);
        int k;
        q = 8'hxx;
        addr = a;
        rnw = rd;
        wr_data = rd ? ~wr_data : d;
        wr_oe = !rd;
        repeat (3) @(negedge clock);
        ncs = 1'b0;
        for (k = 0; k < (rd ? 12 : 5); k++)
        begin
            @(negedge clock);
            if (rd && rd_oe === 1'b1)
                break;
        end
        if (rd && rd_oe === 1'b1)
            q = rd_data;
        ncs = 1'b1;
        // released pins show the inverse of the last value
        wr_oe = 1'b0;
        wr_data = ~wr_data;
        repeat (4) @(negedge clock);
    endtask
endmodule

// ---- tb/tuner_control_regs_sync_tb.sv ----
module tuner_control_regs_sync_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import tuner_pkg::*;

    logic       clock = 1'b0;
    logic       nrst, ncs, rnw, hoe, doe, acc, diag, gsync, nso, nos;
    logic       nso_q, dg_q;
    logic [2:0] syncs_n;
    addr_t      addr;
    byte_t      hdata, bus, dout, status_in, sig_in;
    byte_t      filt, gm, gsh, ofmt, sctl;
    sample_t    i_s, q_s;
    tuning_t    osc;
    int         n_fail = 0, checked = 0, cyc = 0, n_acc = 0, n_nos = 0;
    int         n_gs = 0, t_so = 0, gap = 0, t_dg = 0, gap_d = 0;

    always #20 clock = ~clock;
    assign bus = (doe && hoe) ? 8'hxx : (doe ? dout : hdata);

    tuner_control_regs_sync dut
    (
        .CLOCK(clock), .NRST(nrst), .NCS(ncs), .RNW(rnw), .ADDR(addr),
        .DATA_IN(bus), .DATA_OUT(dout), .DATA_OE(doe), .NSS(syncs_n[2]),
        .NAS(syncs_n[1]), .NGS(syncs_n[0]), .STATUS_IN(status_in),
        .SIGNATURE_IN(sig_in), .I_SAMPLE(i_s), .Q_SAMPLE(q_s),
        .FILTER_MODE(filt), .GAIN_MANTISSA(gm), .GAIN_SHIFT(gsh),
        .OUTPUT_FORMAT(ofmt), .STATUS_CTRL(sctl), .OSC_TUNING_WORD(osc),
        .ACC_RESET(acc), .DIAG_SYNC(diag), .GAIN_SYNC(gsync), .NSO(nso),
        .NOS(nos)
    );

    tuner_host host
    (
        .clock(clock), .rd_data(dout), .rd_oe(doe), .ncs(ncs), .rnw(rnw),
        .addr(addr), .wr_data(hdata), .wr_oe(hoe)
    );

    always @(negedge clock)
    begin
        cyc++;
        n_acc += (acc === 1'b1);
        n_gs += (gsync === 1'b1);
        n_nos += (nos === 1'b0);
        if (nso_q === 1'b1 && nso === 1'b0)
        begin
            gap = cyc - t_so;
            t_so = cyc;
        end
        if (dg_q === 1'b0 && diag === 1'b1)
        begin
            gap_d = cyc - t_dg;
            t_dg = cyc;
        end
        nso_q = nso;
        dg_q = diag;
    end

    function automatic byte_t pat(input int i);
        return (i == 4) ? 8'h44 : 8'(i * 37 + 90);
    endfunction

    task automatic chk(input string w, input logic [27:0] e,
                       input logic [27:0] g);
        checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", w, e, g);
        end
    endtask

    task automatic clk(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic wr(input int a, input byte_t d);
        byte_t q;
        host.access(4'(a), 1'b0, d, q);
    endtask

    task automatic rd(input int a, input byte_t e, input string w);
        byte_t q;
        host.access(4'(a), 1'b1, 8'h00, q);
        chk(w, 28'(e), 28'(q));
    endtask

    task automatic spulse(input logic [2:0] m);
        syncs_n = ~m;
        clk(6);
        syncs_n = 3'b111;
        clk(8);
    endtask

    // set routing, stage a new low byte, fire one sync pin
    task automatic route(input byte_t mode, input byte_t b0,
                         input logic [2:0] pin, input tuning_t e,
                         input int da);
        int a0;
        wr(4, mode);
        wr(0, b0);
        a0 = n_acc;
        spulse(pin);
        chk("frequency after sync", e, osc);
        chk("accumulator resets", 28'(da), 28'(n_acc - a0));
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        int i;
        nrst = 1'b0;
        syncs_n = 3'b111;
        status_in = 8'h3c;
        sig_in = 8'h96;
        i_s = 16'h1234;
        q_s = 16'hfedc;
        clk(3);
        nrst = 1'b1;
        for (i = 0; i < 9; i++)
            rd(i, 8'h00, "reset value");
        $display("test reset done");
        for (i = 0; i < 10; i++)
            wr(i, pat(i));
        for (i = 0; i < 9; i++)
            rd(i, pat(i), "readback");
        rd(9, status_in, "status");
        chk("filter", 28'(pat(5)), 28'(filt));
        chk("mantissa", 28'(pat(6)), 28'(gm));
        chk("shift", 28'(pat(7)), 28'(gsh));
        chk("format", 28'(pat(8)), 28'(ofmt));
        chk("status ctrl", 28'(pat(9)), 28'(sctl));
        $display("test readback done");
        for (i = 10; i < 16; i++)
            wr(i, 8'hff);
        chk("one-shot pulses", 28'h1, 28'(n_nos));
        rd(10, 8'h00, "one-shot read");
        rd(11, sig_in, "signature");
        rd(12, i_s[7:0], "i low");
        rd(13, i_s[15:8], "i high");
        rd(14, q_s[7:0], "q low");
        rd(15, q_s[15:8], "q high");
        $display("test read-only done");
        wr(0, 8'h21);
        wr(1, 8'h43);
        wr(2, 8'h65);
        wr(3, 8'hf7);
        chk("frequency idle", 28'h0, osc);
        wr(4, 8'h08);
        chk("frequency load", 28'h765_4321, osc);
        wr(0, 8'h99);
        chk("frequency reload", 28'h765_4399, osc);
        $display("test load-now done");
        route(8'h12, 8'h11, 3'b010, 28'h765_4311, 1);
        route(8'h10, 8'h22, 3'b010, 28'h765_4322, 0);
        route(8'h02, 8'h33, 3'b010, 28'h765_4322, 1);
        route(8'h16, 8'h44, 3'b010, 28'h765_4322, 0);
        route(8'h16, 8'h55, 3'b100, 28'h765_4355, 1);
        route(8'h17, 8'h66, 3'b100, 28'h765_4355, 0);
        route(8'h17, 8'h77, 3'b010, 28'h765_4377, 1);
        $display("test routing done");
        syncs_n = 3'b011;
        clk(5);
        chk("sync out low", 28'h0, 28'(nso));
        syncs_n = 3'b111;
        clk(5);
        chk("sync out high", 28'h1, 28'(nso));
        i = n_gs;
        spulse(3'b001);
        chk("gain syncs", 28'h1, 28'(n_gs - i));
        wr(4, 8'h20);
        spulse(3'b100);
        spulse(3'b100);
        chk("diag follows system sync", 28'he, 28'(gap_d));
        $display("test sync out done");
        wr(4, 8'he0);
        clk(600);
        chk("counter period", 28'h100, 28'(gap));
        chk("diag period", 28'h100, 28'(gap_d));
        @(negedge clock iff nso === 1'b0);
        clk(1);
        chk("strobe width", 28'h1, 28'(nso));
        $display("test counter done");
        conclude();
    end

    initial
    begin
        repeat (20000) @(posedge clock);
        n_fail++;
        $display("[ERR] watchdog expected finish seen hang");
        conclude();
    end
endmodule
